// ---- verif/cdie_host.sv ----
// Host interrupt input counting line assertions
`timescale 1ns/1ps
module cdie_host (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       irq,
   output reg  [7:0] hits_q);
   reg last_q;
   always @(posedge ref_clk or posedge rst)
      if (rst) {hits_q, last_q} <= 9'h000;
      else {hits_q, last_q} <= {hits_q + {7'h00, irq & ~last_q}, irq};
endmodule

// ---- verif/cdie_props.sv ----
// Bus handshake properties of the enable group
`timescale 1ns/1ps
module cdie_props (
   input wire ref_clk,
   input wire rst,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_BH: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid lost");
   AST_RH: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid lost");
   AST_BD: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   AST_RD: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stuck");
   AST_RL: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("rvalid late");
   AST_AB: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar busy");
   AST_AW: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw busy");
   AST_WB: assert property (s_axi_bvalid |-> !s_axi_wready) else $error("w busy");
endmodule
bind cdie_top cdie_props u_props (.*);

// ---- verif/cdie_top_bench.sv ----
// Bus and event bench for the enable group
`timescale 1ns/1ps
module cdie_top_bench;
   logic ref_clk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h0, s_axi_rready = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, dn = 32'h0, m;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, capture_dma_irq_line3;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] hits_q;
   int miscompares = 0, check_count = 0, cyc = 0;
   cdie_top DUT (.*, .done_in2_pb_multi(dn[31:28]), .done_in2_pa_multi(dn[27:12]),
      .done_in1_pb_rgb(dn[11]), .done_in1_pa_rgb(dn[10]), .done_in1_pb_chroma(dn[9]),
      .done_in1_pb_luma(dn[8]), .done_in1_pa_chroma(dn[7]), .done_in1_pa_luma(dn[6]),
      .done_in1_pb_anc(dn[5:0]));
   cdie_host u_host (.ref_clk, .rst, .irq(capture_dma_irq_line3), .hits_q);
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("%0d checks, %0d miscompares", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input [31:0] s, input [31:0] e);
      check_count++;
      miscompares += (s !== e);
      if (s !== e) $display("[FAIL] %0t seen %h expected %h", $time, s, e);
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d, input [1:0] r);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      do begin
         @(posedge ref_clk);
         s_axi_awvalid <= s_axi_awvalid & !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid & !s_axi_wready;
         s_axi_arvalid <= s_axi_arvalid & !s_axi_arready;
      end while (!(w ? s_axi_bvalid : s_axi_rvalid));
      chk({30'h0, (w ? s_axi_bresp : s_axi_rresp)}, {30'h0, r});
      if (!w) chk(s_axi_rdata, d);
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'h0;
      xfer(1'h0, 12'h14C, 32'h0, 2'h0);
      xfer(1'h1, 12'h150, 32'h0, 2'h2);
      xfer(1'h0, 12'h150, 32'h0, 2'h2);
      for (m = 32'h1; m != 32'h0; m = m << 1) begin
         xfer(1'h1, 12'h14C, ~m, 2'h0);
         @(posedge ref_clk) dn <= m;
         @(posedge ref_clk) dn <= 32'h0;
         xfer(1'h0, 12'h148, m, 2'h0);
         chk({31'h0, capture_dma_irq_line3}, 32'h0);
         xfer(1'h1, 12'h14C, m, 2'h0);
         xfer(1'h0, 12'h14C, m, 2'h0);
         chk({31'h0, capture_dma_irq_line3}, 32'h1);
         xfer(1'h1, 12'h148, m, 2'h0);
         xfer(1'h0, 12'h148, 32'h0, 2'h0);
         chk({31'h0, capture_dma_irq_line3}, 32'h0);
      end
      chk({24'h0, hits_q}, 32'h20);
      xfer(1'h1, 12'h14C, 32'hFFFFFFFF, 2'h0);
      @(posedge ref_clk) s_axi_wstrb <= 4'h5;
      xfer(1'h1, 12'h14C, 32'h00000000, 2'h0);
      @(posedge ref_clk) s_axi_wstrb <= 4'hF;
      xfer(1'h0, 12'h14C, 32'hFF00FF00, 2'h0);
      @(posedge ref_clk) rst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      xfer(1'h0, 12'h14C, 32'h0, 2'h0);
      xfer(1'h0, 12'h148, 32'h0, 2'h0);
      chk({31'h0, capture_dma_irq_line3}, 32'h0);
      report_and_stop;
   end
endmodule

// ---- verilog/cdie_defs.vh ----
// Offsets, field positions and reset values of the capture interrupt enable group
`ifndef CDIE_DEFS_VH
`define CDIE_DEFS_VH
`define CDIE_ADDR_W         12
`define CDIE_OFF_ENABLE     12'h14C
`define CDIE_OFF_STATUS     12'h148
`define CDIE_RST_ENABLE     32'h00000000
`define CDIE_RST_STATUS     32'h00000000
`define CDIE_F_IN2_PB_HI    31
`define CDIE_F_IN2_PB_LO    28
`define CDIE_F_IN2_PA_HI    27
`define CDIE_F_IN2_PA_LO    12
`define CDIE_F_IN1_PB_RGB   11
`define CDIE_F_IN1_PA_RGB   10
`define CDIE_F_IN1_PB_CHR   9
`define CDIE_F_IN1_PB_LUM   8
`define CDIE_F_IN1_PA_CHR   7
`define CDIE_F_IN1_PA_LUM   6
`define CDIE_F_IN1_ANC_HI   5
`define CDIE_F_IN1_ANC_LO   0
`define CDIE_RESP_OKAY      2'h0
`define CDIE_RESP_SLVERR    2'h2
`endif

// ---- verilog/cdie_top.v ----
// Capture DMA interrupt enable group three with status flags and AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cdie_defs.vh"

// Operation
// - Enable register at 14Ch, 32 bits, read-write, cleared by reset.
// - Enabled channel completion drives interrupt line three; disabled bit blocks it.
// - Bits 31..28 enable input two port B multi-source channels 3..0.
// - Bits 27..12 enable input two port A multi-source channels 15..0.
// - Bit 11 input one port B RGB, bit 10 port A RGB.
// - Bits 9..6 input one port B chroma, B luma, A chroma, A luma.
// - Bits 5..0 enable input one port B ancillary channels 15..10.
// - Completion sets status flag; held until software writes one to clear.
module cdie_top (
   ref_clk,
   rst,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   done_in2_pb_multi,
   done_in2_pa_multi,
   done_in1_pb_rgb,
   done_in1_pa_rgb,
   done_in1_pb_chroma,
   done_in1_pb_luma,
   done_in1_pa_chroma,
   done_in1_pa_luma,
   done_in1_pb_anc,
   capture_dma_irq_line3
);
   input  wire                     ref_clk;
   input  wire                     rst;
   input  wire [`CDIE_ADDR_W-1:0]  s_axi_awaddr;
   input  wire                     s_axi_awvalid;
   output reg                      s_axi_awready;
   input  wire [31:0]              s_axi_wdata;
   input  wire [3:0]               s_axi_wstrb;
   input  wire                     s_axi_wvalid;
   output reg                      s_axi_wready;
   output reg  [1:0]               s_axi_bresp;
   output reg                      s_axi_bvalid;
   input  wire                     s_axi_bready;
   input  wire [`CDIE_ADDR_W-1:0]  s_axi_araddr;
   input  wire                     s_axi_arvalid;
   output reg                      s_axi_arready;
   output reg  [31:0]              s_axi_rdata;
   output reg  [1:0]               s_axi_rresp;
   output reg                      s_axi_rvalid;
   input  wire                     s_axi_rready;
   input  wire [3:0]               done_in2_pb_multi;
   input  wire [15:0]              done_in2_pa_multi;
   input  wire                     done_in1_pb_rgb;
   input  wire                     done_in1_pa_rgb;
   input  wire                     done_in1_pb_chroma;
   input  wire                     done_in1_pb_luma;
   input  wire                     done_in1_pa_chroma;
   input  wire                     done_in1_pa_luma;
   input  wire [5:0]               done_in1_pb_anc;
   output reg                      capture_dma_irq_line3;

   // ==================================================================
   // Byte-lane merge
   function [31:0] strb_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      i;
      begin
         strb_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // ==================================================================
   // Register decode
   localparam [`CDIE_ADDR_W-1:0] OFF_ENABLE = `CDIE_OFF_ENABLE;
   localparam [`CDIE_ADDR_W-1:0] OFF_STATUS = `CDIE_OFF_STATUS;
   localparam [1:0]              SEL_NONE   = 2'h0;
   localparam [1:0]              SEL_ENABLE = 2'h1;
   localparam [1:0]              SEL_STATUS = 2'h2;

   function [1:0] reg_sel;
      input [`CDIE_ADDR_W-1:0] addr;
      begin
         if (addr[`CDIE_ADDR_W-1:2] == OFF_ENABLE[`CDIE_ADDR_W-1:2]) begin
            reg_sel = SEL_ENABLE;
         end else if (addr[`CDIE_ADDR_W-1:2] == OFF_STATUS[`CDIE_ADDR_W-1:2]) begin
            reg_sel = SEL_STATUS;
         end else begin
            reg_sel = SEL_NONE;
         end
      end
   endfunction

   // ==================================================================
   // Event vector in enable-bit order
   wire [31:0] evt;
   assign evt[`CDIE_F_IN2_PB_HI:`CDIE_F_IN2_PB_LO] = done_in2_pb_multi;
   assign evt[`CDIE_F_IN2_PA_HI:`CDIE_F_IN2_PA_LO] = done_in2_pa_multi;
   assign evt[`CDIE_F_IN1_PB_RGB] = done_in1_pb_rgb;
   assign evt[`CDIE_F_IN1_PA_RGB] = done_in1_pa_rgb;
   assign evt[`CDIE_F_IN1_PB_CHR] = done_in1_pb_chroma;
   assign evt[`CDIE_F_IN1_PB_LUM] = done_in1_pb_luma;
   assign evt[`CDIE_F_IN1_PA_CHR] = done_in1_pa_chroma;
   assign evt[`CDIE_F_IN1_PA_LUM] = done_in1_pa_luma;
   assign evt[`CDIE_F_IN1_ANC_HI:`CDIE_F_IN1_ANC_LO] = done_in1_pb_anc;

   // ==================================================================
   // Write channel capture
   reg                     aw_have_q;
   reg [`CDIE_ADDR_W-1:0]  aw_addr_q;
   reg                     w_have_q;
   reg [31:0]              w_data_q;
   reg [3:0]               w_strb_q;
   reg [31:0]              enable_q;
   reg [31:0]              status_q;
   reg [31:0]              enable_d;
   reg [31:0]              status_d;
   reg [1:0]               wr_resp_d;
   wire                    wr_go;

   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

   always @* begin
      enable_d  = enable_q;
      wr_resp_d = `CDIE_RESP_OKAY;
      status_d  = status_q;
      if (wr_go) begin
         if (reg_sel(aw_addr_q) == SEL_ENABLE) begin
            enable_d = strb_merge(enable_q, w_data_q, w_strb_q);
         end else if (reg_sel(aw_addr_q) == SEL_STATUS) begin
            status_d = status_q & ~strb_merge(32'h00000000, w_data_q, w_strb_q);
         end else begin
            wr_resp_d = `CDIE_RESP_SLVERR;
         end
      end
      status_d = status_d | evt;
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= {`CDIE_ADDR_W{1'b0}};
         w_have_q      <= 1'b0;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CDIE_RESP_OKAY;
         enable_q      <= `CDIE_RST_ENABLE;
         status_q      <= `CDIE_RST_STATUS;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_resp_d;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         enable_q <= enable_d;
         status_q <= status_d;
      end
   end

   // ==================================================================
   // Read channel
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `CDIE_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CDIE_RESP_OKAY;
            if (reg_sel(s_axi_araddr) == SEL_ENABLE) begin
               s_axi_rdata <= enable_q;
            end else if (reg_sel(s_axi_araddr) == SEL_STATUS) begin
               s_axi_rdata <= status_q;
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `CDIE_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Interrupt line
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         capture_dma_irq_line3 <= 1'b0;
      end else begin
         capture_dma_irq_line3 <= |(status_q & enable_q);
      end
   end
endmodule
